//--- pnpcr_buf2.sv
// pnpcr_buf2: two-entry buffer with valid/ready on both sides
// assumes: single clock, async active-low reset
`timescale 1ns/1ps
module pnpcr_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wrPtr_q;
  logic             rdPtr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wrPtr_q <= ~wrPtr_q;
      if (pop) rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // pnpcr_buf2

//--- pnpcr_host.sv
// pnpcr_host: isa host model issuing one-cycle io strobes
// assumes: strobes taken on the rising edge, answer one edge later
`timescale 1ns/1ps
module pnpcr_host
  import pnpcr_pkg::*;
(
  // clock
  input wire logic       clk,
  // isa strobes
  output logic           isaWrite,
  output pnpcr_bus_type  isaWrBus,
  output logic           isaRead,
  output logic [15:0]    isaRdAddr,
  // read answer
  input wire logic       isaRdDrive,
  input wire logic [7:0] isaRdData
);
  initial begin
    isaWrite  = 1'b0;
    isaRead   = 1'b0;
    isaWrBus  = '0;
    isaRdAddr = 16'h0000;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    isaWrite <= 1'b1;
    isaWrBus <= pnpcr_bus_type'({a, d});
    @(posedge clk);
    isaWrite <= 1'b0;
    // idle bus shows garbage, not the last value
    isaWrBus <= pnpcr_bus_type'(~{a, d});
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic drv);
    @(posedge clk);
    isaRead   <= 1'b1;
    isaRdAddr <= a;
    @(posedge clk);
    isaRead   <= 1'b0;
    isaRdAddr <= ~a;
    #1;
    drv = isaRdDrive;
    d   = isaRdData;
  endtask
  task automatic key();
    logic [7:0] k;
    k = 8'h6a;
    repeat (32) begin
      wr(16'h0279, k);
      k = {k[1] ^ k[0], k[7:1]};
    end
  endtask
endmodule // pnpcr_host

//--- pnpcr_pkg.sv
// pnpcr_pkg: constants and carrier types for the plug and play register bank
// assumes: included before the modules that use it
package pnpcr_pkg;
  localparam logic [7:0]  IDX_RDPORT = 8'h00;
  localparam logic [7:0]  IDX_SERIAL = 8'h01;
  localparam logic [7:0]  IDX_CTRL   = 8'h02;
  localparam logic [7:0]  IDX_WAKE   = 8'h03;
  localparam logic [7:0]  IDX_RDATA  = 8'h04;
  localparam logic [7:0]  IDX_STATUS = 8'h05;
  localparam logic [7:0]  IDX_CSN    = 8'h06;
  localparam logic [7:0]  IDX_LDN    = 8'h07;
  localparam logic [7:0]  IDX_ACT    = 8'h30;
  localparam logic [7:0]  IDX_RCHK   = 8'h31;
  localparam logic [7:0]  IDX_ROMHI  = 8'h40;
  localparam logic [7:0]  IDX_ROMLO  = 8'h41;
  localparam logic [7:0]  IDX_MEMCTL = 8'h42;
  localparam logic [7:0]  IDX_IOHI   = 8'h60;
  localparam logic [7:0]  IDX_IOLO   = 8'h61;
  localparam logic [7:0]  IDX_IRQLV  = 8'h70;
  localparam logic [7:0]  IDX_IRQTY  = 8'h71;
  // isa port addresses of the index and write-data ports
  localparam logic [15:0] PORT_INDEX = 16'h0279;
  localparam logic [15:0] PORT_WDATA = 16'h0a79;
  localparam logic [1:0]  RDPORT_LOW = 2'h3;
  // writable masks of mixed registers
  localparam logic [7:0]  MASK_ROMHI = 8'h0d;
  localparam logic [7:0]  MASK_ROMLO = 8'hc0;
  localparam logic [7:0]  MASK_IOHI  = 8'h03;
  localparam logic [7:0]  MASK_IOLO  = 8'he0;
  localparam logic [7:0]  MASK_IRQLV = 8'h0f;
  localparam logic [7:0]  VAL_ZERO   = 8'h00;
  localparam logic [7:0]  VAL_IRQTY  = 8'h02;
  localparam logic [7:0]  VAL_CHK1   = 8'h55;
  localparam logic [7:0]  VAL_CHK0   = 8'haa;
  localparam int          BIT_RST    = 0;
  localparam int          BIT_WFK    = 1;
  localparam int          BIT_RCSN   = 2;
  localparam int          BIT_ACT    = 0;
  localparam int          BIT_CHKPAT = 0;
  localparam int          BIT_CHKEN  = 1;
  localparam int          KEY_LEN    = 32;
  localparam int          SERIAL_LEN = 72;

  typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} pnpcr_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } pnpcr_bus_type;

  typedef struct packed {
    logic [7:0] romHi;
    logic [7:0] romLo;
    logic [7:0] ioHi;
    logic [7:0] ioLo;
    logic [7:0] irqLevel;
  } pnpcr_cfg_type;

  // initiation key value at step n: lfsr seeded with 6a
  function automatic logic [7:0] pnpcr_key_next(input logic [7:0] k);
    pnpcr_key_next = {k[1] ^ k[0], k[7:1]};
  endfunction
  localparam logic [7:0] KEY_SEED = 8'h6a;
endpackage

//--- pnpcr_registers.sv
// pnpcr_registers: plug and play card and logical device register bank
// assumes: isa cycles arrive as one-cycle strobes synchronous to clk;
// resource bytes stream in through a valid/ready port; serial id is a fixed input
//
// Contract
// - read port address from written byte
// - isolation read compares next serial bit
// - bit0 resets device config, keeps select
// - bit1 returns to wait-for-key state
// - bit2 clears select number and backup
// - control command bits self clear
// - wake moves matching sleeper onward
// - resource read returns next byte
// - status bit0 only when byte ready
// - logical device number reads zero
// - activate bit0 enables bus response
// - range check only while inactive
// - range check reads 55 or aa
// - rom high bits 23-20,17 fixed zero
// - rom low bits 13-8 fixed zero
// - memory control reads zero
// - io high bits 15-10 fixed zero
// - io low bits 4-0 fixed zero
// - irq level selects line, zero none
// - irq type reads constant 02
// - index port then data port accesses
// - undefined registers read zero
// - ports disabled until initiation key
`timescale 1ns/1ps
module pnpcr_registers
  import pnpcr_pkg::*;
#(
  parameter int SERIAL_BITS = SERIAL_LEN
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // isa write cycle strobe
  input  wire logic                   isaWrite,
  input  wire pnpcr_bus_type          isaWrBus,
  // isa read cycle strobe
  input  wire logic                   isaRead,
  input  wire logic [15:0]            isaRdAddr,
  output logic                        isaRdDrive,
  output logic [7:0]                  isaRdData,
  // serial identifier and isolation bus level
  input  wire logic [SERIAL_BITS-1:0] serialId,
  input  wire logic                   isoLineIn,
  // resource byte stream
  input  wire logic                   resValid,
  output logic                        resReady,
  input  wire logic [7:0]             resData,
  // configuration outputs
  output logic                        deviceActive,
  output logic                        rangeCheckOn,
  output pnpcr_cfg_type               cfgOut,
  output logic [7:0]                  card_select_number,
  output logic [7:0]                  saved_select_number,
  output logic [9:0]                  readPortAddr,
  output pnpcr_state_type             cardState
);
  pnpcr_state_type state_q;
  logic [7:0]  index_q;
  logic [7:0]  rdPortHi_q;
  logic [7:0]  csn_q;
  logic [7:0]  csnSave_q;
  logic [7:0]  keyExp_q;
  logic [5:0]  keyCnt_q;
  logic        keyOk_q;
  logic [7:0]  serialPos_q;
  logic        active_q;
  logic [1:0]  rangeChk_q;
  pnpcr_cfg_type cfg_q;
  logic [7:0]  rdData_q;
  logic        rdDrive_q;
  logic        bufValid;
  logic [7:0]  bufData;
  logic        bufPop;
  logic        idxWr;
  logic        dataWr;
  logic        portRd;
  logic        cfgWr;
  logic        inCfg;
  logic        ioRd;
  logic [7:0]  wd;
  logic [15:0] ioBase;
  logic        cmdReset;
  logic        cmdWaitKey;
  logic        cmdClrCsn;
  logic        isoOwnBit;
  logic        isoDrop;

  assign wd     = isaWrBus.data;
  assign inCfg  = (state_q == ST_CONFIG);
  assign idxWr  = isaWrite && (isaWrBus.addr == PORT_INDEX);
  assign dataWr = isaWrite && (isaWrBus.addr == PORT_WDATA) && keyOk_q;
  // read port at bits 9:2, low bits one
  assign readPortAddr = {rdPortHi_q, RDPORT_LOW};
  assign portRd = isaRead && keyOk_q && (isaRdAddr[9:0] == readPortAddr) && (isaRdAddr[15:10] == 6'h00);
  // only config state writes config registers
  assign cfgWr  = dataWr && inCfg;
  assign ioBase = {cfg_q.ioHi, cfg_q.ioLo};
  assign ioRd   = isaRead && (isaRdAddr[15:5] == ioBase[15:5]);
  assign bufPop = portRd && inCfg && (index_q == IDX_RDATA);

  // one decode for the three command bits; all inputs as arguments so a net assign sees every change
  function automatic logic pnpcr_ctrl_cmd(input logic wr, input logic [7:0] idx, input logic [7:0] data,
                                          input int bitPos);
    pnpcr_ctrl_cmd = wr && (idx == IDX_CTRL) && data[bitPos];
  endfunction

  // command strobes live one cycle, nothing to clear afterwards
  assign cmdReset   = pnpcr_ctrl_cmd(cfgWr, index_q, wd, BIT_RST);
  assign cmdWaitKey = pnpcr_ctrl_cmd(dataWr, index_q, wd, BIT_WFK);
  assign cmdClrCsn  = pnpcr_ctrl_cmd(dataWr, index_q, wd, BIT_RCSN);
  // serial bit under test for the current read pair
  assign isoOwnBit  = serialId[serialPos_q[7:1]];
  // a zero bit loses to another card driving the line
  assign isoDrop    = portRd && (index_q == IDX_SERIAL) && serialPos_q[0] && !isoOwnBit && isoLineIn;

  // resource bytes wait here; a slow host stalls the producer, no byte lost
  pnpcr_buf2 #(
    .WIDTH(8)
  ) u_resBuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (resValid),
    .inReady  (resReady),
    .inData   (resData),
    .outValid (bufValid),
    .outReady (bufPop),
    .outData  (bufData)
  );

  // initiation key detector on index writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keyExp_q <= KEY_SEED;
      keyCnt_q <= 6'h00;
      keyOk_q  <= 1'b0;
    end else if (cmdWaitKey) begin
      keyOk_q  <= 1'b0;
      keyExp_q <= KEY_SEED;
      keyCnt_q <= 6'h00;
    end else if (idxWr && !keyOk_q) begin
      if (wd == keyExp_q) begin
        if (keyCnt_q == 6'(KEY_LEN - 1)) begin
          keyOk_q  <= 1'b1;
          keyExp_q <= KEY_SEED;
          keyCnt_q <= 6'h00;
        end else begin
          keyExp_q <= pnpcr_key_next(keyExp_q);
          keyCnt_q <= keyCnt_q + 6'h01;
        end
      end else begin
        // mismatch restarts; a seed value re-arms at step one
        keyExp_q <= (wd == KEY_SEED) ? pnpcr_key_next(KEY_SEED) : KEY_SEED;
        keyCnt_q <= (wd == KEY_SEED) ? 6'h01 : 6'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_q <= VAL_ZERO;
    end else if (idxWr && keyOk_q) begin
      index_q <= wd;
    end
  end

  // card state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_WAIT_KEY;
    end else begin
      case (state_q)
        ST_WAIT_KEY: begin
          if (idxWr && !keyOk_q && (keyCnt_q == 6'(KEY_LEN - 1)) && (wd == keyExp_q)) state_q <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (dataWr && (index_q == IDX_WAKE) && (wd == csn_q))
            state_q <= (wd == VAL_ZERO) ? ST_ISOLATE : ST_CONFIG;
        end
        ST_ISOLATE: begin
          if (dataWr && (index_q == IDX_CSN)) state_q <= ST_CONFIG;
          else if (dataWr && (index_q == IDX_WAKE) && (wd != csn_q)) state_q <= ST_SLEEP;
          else if (isoDrop) state_q <= ST_SLEEP;
        end
        ST_CONFIG: begin
          if (dataWr && (index_q == IDX_WAKE) && (wd != csn_q)) state_q <= ST_SLEEP;
        end
        default: state_q <= ST_WAIT_KEY;
      endcase
      if (cmdWaitKey) state_q <= ST_WAIT_KEY;
    end
  end

  // each isolation read steps the serial pair position
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serialPos_q <= VAL_ZERO;
    end else if (state_q != ST_ISOLATE) begin
      serialPos_q <= VAL_ZERO;
    end else if (portRd && (index_q == IDX_SERIAL)) begin
      serialPos_q <= (serialPos_q == 8'(2 * SERIAL_BITS - 1)) ? VAL_ZERO : serialPos_q + 8'h01;
    end
  end

  // select number and backup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csn_q     <= VAL_ZERO;
      csnSave_q <= VAL_ZERO;
    end else if (cmdClrCsn) begin
      csn_q     <= VAL_ZERO;
      csnSave_q <= VAL_ZERO;
    end else if (dataWr && (index_q == IDX_CSN) && (inCfg || state_q == ST_ISOLATE)) begin
      csn_q     <= wd;
      csnSave_q <= wd;
    end
  end

  // read port relocation, config or isolation only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPortHi_q <= VAL_ZERO;
    end else if (dataWr && (inCfg || state_q == ST_ISOLATE) && (index_q == IDX_RDPORT)) begin
      rdPortHi_q <= wd;
    end
  end

  // activate bit, cleared by the reset command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
    end else if (cmdReset) begin
      active_q <= 1'b0;
    end else if (cfgWr && (index_q == IDX_ACT)) begin
      active_q <= wd[BIT_ACT];
    end
  end

  // range check enable and pattern bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rangeChk_q <= 2'h0;
    end else if (cmdReset) begin
      rangeChk_q <= 2'h0;
    end else if (cfgWr && (index_q == IDX_RCHK)) begin
      rangeChk_q <= wd[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
    end else if (cmdReset) begin
      cfg_q <= '0;
    end else if (cfgWr) begin
      case (index_q)
        IDX_ROMHI: cfg_q.romHi <= wd & MASK_ROMHI;
        IDX_ROMLO: cfg_q.romLo <= wd & MASK_ROMLO;
        IDX_IOHI:  cfg_q.ioHi <= wd & MASK_IOHI;
        IDX_IOLO:  cfg_q.ioLo <= wd & MASK_IOLO;
        IDX_IRQLV: cfg_q.irqLevel <= wd & MASK_IRQLV;
        // fixed and unknown indices ignore writes
        default:   cfg_q <= cfg_q;
      endcase
    end
  end

  // read data mux
  function automatic logic [7:0] pnpcr_reg_read(input logic [7:0] idx, input logic isoBit);
    case (idx)
      IDX_SERIAL: pnpcr_reg_read = isoBit ? VAL_CHK1 : VAL_CHK0;
      IDX_RDATA:  pnpcr_reg_read = bufData;
      IDX_STATUS: pnpcr_reg_read = {7'h00, bufValid};
      IDX_CSN:    pnpcr_reg_read = csn_q;
      IDX_LDN:    pnpcr_reg_read = VAL_ZERO;
      IDX_ACT:    pnpcr_reg_read = {7'h00, active_q};
      IDX_RCHK:   pnpcr_reg_read = {6'h00, rangeChk_q};
      IDX_ROMHI:  pnpcr_reg_read = cfg_q.romHi;
      IDX_ROMLO:  pnpcr_reg_read = cfg_q.romLo;
      IDX_MEMCTL: pnpcr_reg_read = VAL_ZERO;
      IDX_IOHI:   pnpcr_reg_read = cfg_q.ioHi;
      IDX_IOLO:   pnpcr_reg_read = cfg_q.ioLo;
      IDX_IRQLV:  pnpcr_reg_read = cfg_q.irqLevel;
      IDX_IRQTY:  pnpcr_reg_read = VAL_IRQTY;
      default:    pnpcr_reg_read = VAL_ZERO;
    endcase
  endfunction

  // registered read answer, one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q  <= VAL_ZERO;
      rdDrive_q <= 1'b0;
    end else if (portRd && inCfg) begin
      rdData_q  <= pnpcr_reg_read(index_q, 1'b0);
      rdDrive_q <= 1'b1;
    end else if (portRd && (state_q == ST_ISOLATE) && (index_q == IDX_SERIAL)) begin
      // isolation pairs: 55 then aa for a one bit, wired-and line seen otherwise
      rdData_q  <= (isoOwnBit ? (serialPos_q[0] ? VAL_CHK0 : VAL_CHK1) : VAL_ZERO);
      rdDrive_q <= isoOwnBit;
    end else if (ioRd && rangeChk_q[BIT_CHKEN] && !active_q) begin
      rdData_q  <= rangeChk_q[BIT_CHKPAT] ? VAL_CHK1 : VAL_CHK0;
      rdDrive_q <= 1'b1;
    end else begin
      rdDrive_q <= 1'b0;
    end
  end

  // commands act once; no stored command bits
  assign isaRdDrive          = rdDrive_q;
  assign isaRdData           = rdData_q;
  assign deviceActive        = active_q;
  assign rangeCheckOn        = rangeChk_q[BIT_CHKEN] && !active_q;
  assign cfgOut              = cfg_q;
  assign card_select_number  = csn_q;
  assign saved_select_number = csnSave_q;
  assign cardState           = state_q;
endmodule // pnpcr_registers

//--- pnpcr_registers_props.sv
// pnpcr_registers_props: port assertions for the register bank
// assumes: bound to pnpcr_registers, one clock, async active-low reset
`timescale 1ns/1ps
module pnpcr_registers_props
  import pnpcr_pkg::*;
(
  // clock and reset
  input wire logic            clk,
  input wire logic            rst_b,
  // isa strobes and answer
  input wire logic            isaWrite,
  input wire logic            isaRead,
  input wire logic            isaRdDrive,
  // state and configuration
  input wire logic            deviceActive,
  input wire logic            rangeCheckOn,
  input wire pnpcr_cfg_type   cfgOut,
  input wire logic [7:0]      card_select_number,
  input wire logic [7:0]      saved_select_number,
  input wire logic [9:0]      readPortAddr,
  input wire pnpcr_state_type cardState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wakeToCfg;
    cardState == ST_SLEEP ##1 cardState == ST_CONFIG;
  endsequence
  AST_RDPORT_LOW: assert property (readPortAddr[1:0] == 2'h3)
    else $error("read port low bits not ones");
  AST_ANSWER_CAUSE: assert property (isaRdDrive |-> $past(isaRead))
    else $error("read answer without read");
  AST_SILENT: assert property (isaRdDrive |-> $past(cardState) inside {ST_CONFIG, ST_ISOLATE})
    else $error("answer outside config");
  AST_ROMHI: assert property ((cfgOut.romHi & 8'hf2) == 8'h00)
    else $error("rom high fixed bits set");
  AST_ROMLO: assert property ((cfgOut.romLo & 8'h3f) == 8'h00)
    else $error("rom low fixed bits set");
  AST_IO_FIXED: assert property ((cfgOut.ioHi & 8'hfc) == 8'h00 && (cfgOut.ioLo & 8'h1f) == 8'h00)
    else $error("io base fixed bits set");
  AST_CHK_INACTIVE: assert property (deviceActive |-> !rangeCheckOn)
    else $error("range check while active");
  AST_WAKE_CFG: assert property (wakeToCfg |-> card_select_number != 8'h00)
    else $error("wake to config with zero select");
  AST_KEY_LOCK: assert property (cardState == ST_WAIT_KEY && !isaWrite |=> cardState == ST_WAIT_KEY)
    else $error("left wait for key without write");
  AST_ACT_BY_WRITE: assert property ($changed(deviceActive) |-> $past(isaWrite))
    else $error("activate changed without write");
  AST_CFG_BY_WRITE: assert property ($changed(cfgOut) |-> $past(isaWrite))
    else $error("config changed without write");
  AST_CSN_SAVE: assert property ($changed(card_select_number) && card_select_number != 8'h00
                                 |-> saved_select_number == card_select_number)
    else $error("saved select not copied");
endmodule // pnpcr_registers_props

//--- test_pnpcr_registers.sv
// test_pnpcr_registers: self-checking bench for the register bank
// assumes: host model drives the isa strobes, bench feeds resource bytes
`timescale 1ns/1ps
module test_pnpcr_registers
  import pnpcr_pkg::*;
;
  logic            clk, rst_b, isaWrite, isaRead, isaRdDrive, resValid, resReady;
  logic            deviceActive, rangeCheckOn, acc, isoLine;
  logic [71:0]     serial;
  pnpcr_bus_type   isaWrBus;
  pnpcr_cfg_type   cfgOut;
  pnpcr_state_type cardState;
  logic [15:0]     isaRdAddr;
  logic [9:0]      readPortAddr, rdPort;
  logic [7:0]      isaRdData, resData, card_select_number, saved_select_number, d, e, r;
  logic [7:0]      mdl [256];
  logic [7:0]      q [$];
  int              miscompares, samples_checked, cycles, seed;
  logic [7:0] tIdx [9] = '{8'h40, 8'h41, 8'h60, 8'h61, 8'h70, 8'h07, 8'h42, 8'h71, 8'h50};
  logic [7:0] tMsk [9] = '{8'h0d, 8'hc0, 8'h03, 8'he0, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] tCst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  pnpcr_host i_host (.clk(clk), .isaWrite(isaWrite), .isaWrBus(isaWrBus), .isaRead(isaRead),
                     .isaRdAddr(isaRdAddr), .isaRdDrive(isaRdDrive), .isaRdData(isaRdData));
  pnpcr_registers i_dut (.clk(clk), .rst_b(rst_b), .isaWrite(isaWrite), .isaWrBus(isaWrBus),
    .isaRead(isaRead), .isaRdAddr(isaRdAddr), .isaRdDrive(isaRdDrive), .isaRdData(isaRdData),
    .serialId(serial), .isoLineIn(isoLine), .resValid(resValid), .resReady(resReady),
    .resData(resData), .deviceActive(deviceActive), .rangeCheckOn(rangeCheckOn), .cfgOut(cfgOut),
    .card_select_number(card_select_number), .saved_select_number(saved_select_number),
    .readPortAddr(readPortAddr), .cardState(cardState));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    i_host.wr(16'h0279, i);
    i_host.wr(16'h0a79, v);
  endtask
  task automatic rdq(input logic [15:0] a, output logic [7:0] v);
    logic drv;
    i_host.rd(a, v, drv);
    // an undriven answer must never pass as data
    if (drv !== 1'b1) v = 'x;
  endtask
  task automatic rreg(input logic [7:0] i, output logic [7:0] v);
    i_host.wr(16'h0279, i);
    rdq({6'h00, rdPort}, v);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    seed = 6;
    serial = 72'h00c3a55a123456789a;
    isoLine = 1'b0;
    rst_b = 1'b0;
    resValid = 1'b0;
    resData = 8'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wreg(8'h30, 8'h01);
    check(deviceActive, 1'b0, "locked");
    i_host.key();
    check(cardState, ST_SLEEP, "key");
    wreg(8'h03, 8'h00);
    check(cardState, ST_ISOLATE, "wake0");
    wreg(8'h00, 8'h80);
    rdPort = 10'h203;
    check(readPortAddr, rdPort, "rdport");
    i_host.wr(16'h0279, 8'h01);
    for (int j = 0; j < 6; j++) begin
      // third pair: own bit zero while another card drives the line
      if (j == 4) isoLine <= 1'b1;
      i_host.rd({6'h00, rdPort}, r, acc);
      e = serial[j / 2] ? ((j % 2) ? 8'haa : 8'h55) : 8'h00;
      check({acc, acc ? r : 8'h00}, {serial[j / 2], e}, "iso");
    end
    check(cardState, ST_SLEEP, "iso drop");
    isoLine <= 1'b0;
    wreg(8'h03, 8'h00);
    wreg(8'h06, 8'h05);
    check(saved_select_number, 8'h05, "csn save");
    wreg(8'h02, 8'h02);
    check({card_select_number, 6'h00, cardState}, {8'h05, 6'h00, ST_WAIT_KEY}, "wfk");
    i_host.key();
    wreg(8'h03, 8'h05);
    check(cardState, ST_CONFIG, "wake5");
    $display("test states done");
    for (int j = 0; j < 9; j++) begin
      d = $random(seed);
      wreg(tIdx[j], d);
      e = (d & tMsk[j]) | tCst[j];
      mdl[tIdx[j]] = e;
      rreg(tIdx[j], r);
      check(r, e, "reg");
    end
    $display("test registers done");
    wreg(8'h31, 8'h03);
    check(rangeCheckOn, 1'b1, "chk on");
    rdq({mdl[8'h60], mdl[8'h61]}, r);
    check(r, 8'h55, "chk 55");
    wreg(8'h31, 8'h02);
    rdq({mdl[8'h60], mdl[8'h61]}, r);
    check(r, 8'haa, "chk aa");
    wreg(8'h31, 8'h00);
    wreg(8'h30, 8'h01);
    rreg(8'h30, r);
    check({r, 7'h00, deviceActive}, 16'h0101, "act");
    wreg(8'h31, 8'h03);
    check(rangeCheckOn, 1'b0, "chk act");
    $display("test activate done");
    resValid <= 1'b1;
    resData <= $random(seed);
    repeat (4) begin
      @(negedge clk);
      acc = resReady;
      @(posedge clk);
      if (acc) begin
        q.push_back(resData);
        resData <= $random(seed);
      end
    end
    resValid <= 1'b0;
    #1;
    check({q.size(), 7'h00, resReady}, 16'h0200, "full");
    while (q.size() > 0) begin
      rreg(8'h05, r);
      check(r, 8'h01, "ready");
      rreg(8'h04, r);
      check(r, q.pop_front(), "res");
    end
    rreg(8'h05, r);
    check(r, 8'h00, "empty");
    $display("test resource done");
    wreg(8'h02, 8'h01);
    check({cfgOut, card_select_number}, 48'h05, "cfg rst");
    wreg(8'h70, 8'h03);
    check(cfgOut.irqLevel, 8'h03, "no repeat");
    wreg(8'h02, 8'h04);
    check({card_select_number, saved_select_number}, 16'h0000, "csn clr");
    wreg(8'h03, 8'h07);
    check(cardState, ST_SLEEP, "wake other");
    wreg(8'h70, 8'h05);
    check(cfgOut.irqLevel, 8'h03, "frozen");
    i_host.rd({6'h00, rdPort}, r, acc);
    check(acc, 1'b0, "silent");
    $display("test commands done");
    tally_and_finish();
  end
endmodule // test_pnpcr_registers
bind pnpcr_registers pnpcr_registers_props i_props (.clk(clk), .rst_b(rst_b), .isaWrite(isaWrite),
  .isaRead(isaRead), .isaRdDrive(isaRdDrive), .deviceActive(deviceActive), .rangeCheckOn(rangeCheckOn),
  .cfgOut(cfgOut), .card_select_number(card_select_number), .saved_select_number(saved_select_number),
  .readPortAddr(readPortAddr), .cardState(cardState));
